// *** common/gssdm_pkg.sv ***
// Constants, field layouts and carrier types for the gantry supervision block.
// Assumes one drive clock; parameters are written by the drive's own
// parameter path and the status word is forwarded to the fieldbus layer.
//
// Operation
// - A synchronized stop raises warning A.97C.
// - Mask digit value 8 to F hides the synchronized-stop warning.
// - Synchronized-stop status sits at bit 31 of the status word.
// - Status bit reads 0 in normal operation, 1 while stopping.
// - Status word layout fixed; bits 0, 8 and 20-23 read zero.
// - In mode 3 both axes go servo off; status stays 0.
// - Alarm on the stopping axis cancels stopping, uses alarm stop method.
// - Alarm stop method defaults to dynamic brake, changeable by parameter.
// - Deviation equals axis A feedback position minus axis B.
// - Alarm level range 0 to 1073741823, default 5242880, immediate.
// - Alarm level zero disables deviation alarm and warning.
// - Warning percent range 10 to 100, default 100, immediate.
// - Servo on and deviation above level raises A.50D on both axes.
// - Servo on and deviation above level*percent/100 raises A.90D.
// - An all-axes alarm on one axis also alarms the other axis.
// - Stopping ends, status 0 and servo off, below end speed.
package gssdm_pkg;

	// -------------------------------------------------------------------
	// Status word bit positions
	// -------------------------------------------------------------------
	localparam int STS_SLOWDOWN_BIT   = 1;
	localparam int STS_BRAKE_BIT      = 9;
	localparam int STS_TORQUE_LIM_BIT = 16;
	localparam int STS_GEN_IN1_BIT    = 24;
	localparam int STS_SYNC_STOP_BIT  = 31;

	// -------------------------------------------------------------------
	// Parameter selectors, reset values and ranges
	// -------------------------------------------------------------------
	localparam logic [2:0]  PSEL_ALARM_LEVEL  = 3'h0;
	localparam logic [2:0]  PSEL_WARN_PERCENT = 3'h1;
	localparam logic [2:0]  PSEL_WARN_MASK    = 3'h2;
	localparam logic [2:0]  PSEL_END_SPEED    = 3'h3;
	localparam logic [2:0]  PSEL_STOP_METHOD  = 3'h4;
	localparam logic [29:0] ALARM_LEVEL_RST   = 30'h0050_0000;
	localparam logic [29:0] ALARM_LEVEL_MAX   = 30'h3fff_ffff;
	localparam logic [6:0]  WARN_PCT_RST      = 7'h64;
	localparam logic [6:0]  WARN_PCT_MIN      = 7'h0a;
	localparam logic [6:0]  WARN_PCT_MAX      = 7'h64;
	localparam logic [36:0] PCT_DIVISOR       = 37'h00_0000_0064;
	localparam logic [15:0] WARN_MASK_RST     = 16'h0000;
	localparam int          MASK_SYNC_HIDE    = 7;
	localparam logic [15:0] END_SPEED_RST     = 16'h0100;
	localparam logic [3:0]  STOP_DYN_BRAKE    = 4'h0;

	// -------------------------------------------------------------------
	// Synchronized stopping modes and event codes
	// -------------------------------------------------------------------
	localparam logic [1:0]  SYNC_MODE_OFF     = 2'h0;
	localparam logic [1:0]  SYNC_MODE_SVOFF   = 2'h3;
	localparam logic [15:0] CODE_NONE         = 16'h0000;
	localparam logic [15:0] CODE_SYNC_WARN    = 16'h097c;
	localparam logic [15:0] CODE_DEV_ALARM    = 16'h050d;
	localparam logic [15:0] CODE_DEV_WARN     = 16'h090d;

	// -------------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		GSSDM_NORMAL   = 2'b00,
		GSSDM_FOLLOW_A = 2'b01,
		GSSDM_FOLLOW_B = 2'b10
	} gssdm_state_type;

	// Per-axis live signals, gathered by the axis logic outside.
	typedef struct packed {
		logic [6:0] general_input;     // Inputs 7 down to 1.
		logic       zero_speed_flag;
		logic       speed_match_flag;
		logic       speed_limit_flag;
		logic       torque_limit_flag;
		logic       origin_reached;
		logic       positioning_complete;
		logic       approach_window_flag;
		logic       distribution_complete;
		logic       reverse_soft_limit;
		logic       forward_soft_limit;
		logic       holding_brake_output;
		logic       emergency_stop_input;
		logic       latch_input_3;
		logic       latch_input_2;
		logic       latch_input_1;
		logic       reverse_overtravel;
		logic       forward_overtravel;
		logic       homing_slowdown_switch;
	} gssdm_axis_io_type;

	typedef struct packed {
		logic              servo_on;
		logic              alarm;       // Any group 1 or 2 alarm active.
		logic              pos_valid;   // Alarm keeps valid position data.
		logic [31:0]       feedback_position;
		logic [15:0]       feedback_speed;  // Magnitude, 1000 units/s.
		gssdm_axis_io_type io;
	} gssdm_axis_type;

endpackage

// *** design/gssdm_core.sv ***
// Gantry supervision: synchronized-stop tracking, status words and the
// inter-axis deviation alarm and warning.
// Assumes all inputs are synchronous to i_clk and that the stopping
// control itself lives in the axis loops, which obey o_svoff_*.
`timescale 1ns/10ps

module gssdm_core (
	// Clock, reset, enable
	input  wire logic                      i_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_ce,
	// Parameter write path
	input  wire logic                      i_param_wr,
	input  wire logic [2:0]                i_param_sel,
	input  wire logic [31:0]               i_param_data,
	input  wire logic [1:0]                i_sync_mode,
	// Axis signals and host commands
	input  wire gssdm_pkg::gssdm_axis_type i_axis_a,
	input  wire gssdm_pkg::gssdm_axis_type i_axis_b,
	input  wire logic                      i_host_svoff,
	input  wire logic                      i_warn_clear,
	input  wire logic                      i_alarm_reset,
	// Status words to the host
	output logic [31:0]                    o_io_signal_status_word_a,
	output logic [31:0]                    o_io_signal_status_word_b,
	// Stopping control
	output logic                           o_sync_stop_status,
	output logic                           o_svoff_a,
	output logic                           o_svoff_b,
	output logic [3:0]                     o_stop_method,
	// Alarms and warnings
	output logic                           o_sync_warning,
	output logic                           o_dev_alarm_a,
	output logic                           o_dev_alarm_b,
	output logic                           o_dev_warning,
	output logic [15:0]                    o_event_code,
	output logic [32:0]                    o_deviation
);

	// ---------------------------------------------------------------
	// Parameter registers
	// ---------------------------------------------------------------
	logic [29:0] level_reg, level_next;
	logic [6:0]  pct_reg, pct_next;
	logic [15:0] mask_reg, mask_next;
	logic [15:0] end_speed_reg, end_speed_next;
	logic [3:0]  method_reg, method_next;

	// Writes land at once; out-of-range values clamp to the nearest limit.
	always_comb begin
		level_next     = level_reg;
		pct_next       = pct_reg;
		mask_next      = mask_reg;
		end_speed_next = end_speed_reg;
		method_next    = method_reg;
		if (i_param_wr) begin
			case (i_param_sel)
				gssdm_pkg::PSEL_ALARM_LEVEL: begin
					if (i_param_data[31:30] != 2'h0)
						level_next = gssdm_pkg::ALARM_LEVEL_MAX;
					else
						level_next = i_param_data[29:0];
				end
				gssdm_pkg::PSEL_WARN_PERCENT: begin
					if (i_param_data > 32'(gssdm_pkg::WARN_PCT_MAX))
						pct_next = gssdm_pkg::WARN_PCT_MAX;
					else if (i_param_data < 32'(gssdm_pkg::WARN_PCT_MIN))
						pct_next = gssdm_pkg::WARN_PCT_MIN;
					else
						pct_next = i_param_data[6:0];
				end
				gssdm_pkg::PSEL_WARN_MASK:   mask_next = i_param_data[15:0];
				gssdm_pkg::PSEL_END_SPEED:   end_speed_next = i_param_data[15:0];
				gssdm_pkg::PSEL_STOP_METHOD: method_next = i_param_data[3:0];
				default: ;
			endcase
		end
	end

	// Reset restores documented defaults, dynamic brake included.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			level_reg     <= gssdm_pkg::ALARM_LEVEL_RST;
			pct_reg       <= gssdm_pkg::WARN_PCT_RST;
			mask_reg      <= gssdm_pkg::WARN_MASK_RST;
			end_speed_reg <= gssdm_pkg::END_SPEED_RST;
			method_reg    <= gssdm_pkg::STOP_DYN_BRAKE;
		end else if (i_ce) begin
			level_reg     <= level_next;
			pct_reg       <= pct_next;
			mask_reg      <= mask_next;
			end_speed_reg <= end_speed_next;
			method_reg    <= method_next;
		end
	end

	// ---------------------------------------------------------------
	// Synchronized stopping tracker
	// ---------------------------------------------------------------
	gssdm_pkg::gssdm_state_type state_reg, state_next;
	logic svoff_a_reg, svoff_a_next;
	logic svoff_b_reg, svoff_b_next;
	logic sync_warn_reg, sync_warn_next;
	logic follow_a_now, follow_b_now, stop_event;

	// The axis that did not alarm follows the one that did while the alarmed axis
	// keeps valid position, else goes servo off. Mode 3 only drops both servos, so
	// the status flag never leaves normal there.
	always_comb begin
		state_next   = state_reg;
		svoff_a_next = 1'b0;
		svoff_b_next = 1'b0;
		follow_a_now = 1'b0;
		follow_b_now = 1'b0;
		stop_event   = 1'b0;
		case (state_reg)
			gssdm_pkg::GSSDM_NORMAL: begin
				if (i_sync_mode == gssdm_pkg::SYNC_MODE_OFF) begin
					state_next = gssdm_pkg::GSSDM_NORMAL;
				end else if (i_axis_a.alarm ^ i_axis_b.alarm) begin
					stop_event = 1'b1;
					if (i_sync_mode == gssdm_pkg::SYNC_MODE_SVOFF) begin
						svoff_a_next = 1'b1;
						svoff_b_next = 1'b1;
					end else if (i_axis_b.alarm) begin
						follow_a_now = i_axis_b.pos_valid;
						svoff_a_next = !i_axis_b.pos_valid;
					end else begin
						follow_b_now = i_axis_a.pos_valid;
						svoff_b_next = !i_axis_a.pos_valid;
					end
					if (follow_a_now)
						state_next = gssdm_pkg::GSSDM_FOLLOW_A;
					else if (follow_b_now)
						state_next = gssdm_pkg::GSSDM_FOLLOW_B;
				end
			end
			gssdm_pkg::GSSDM_FOLLOW_A: begin
				// A stopping-axis alarm cancels at once; its stop method rules.
				if (i_axis_a.alarm || !i_axis_a.servo_on) begin
					state_next = gssdm_pkg::GSSDM_NORMAL;
				end else if (i_host_svoff ||
					i_axis_b.feedback_speed < end_speed_reg) begin
					state_next   = gssdm_pkg::GSSDM_NORMAL;
					svoff_a_next = 1'b1;
				end
			end
			gssdm_pkg::GSSDM_FOLLOW_B: begin
				if (i_axis_b.alarm || !i_axis_b.servo_on) begin
					state_next = gssdm_pkg::GSSDM_NORMAL;
				end else if (i_host_svoff ||
					i_axis_a.feedback_speed < end_speed_reg) begin
					state_next   = gssdm_pkg::GSSDM_NORMAL;
					svoff_b_next = 1'b1;
				end
			end
			default: state_next = gssdm_pkg::GSSDM_NORMAL;
		endcase
		// A new stop event beats a clear in the same cycle.
		sync_warn_next = stop_event || (sync_warn_reg && !i_warn_clear);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg     <= gssdm_pkg::GSSDM_NORMAL;
			svoff_a_reg   <= 1'b0;
			svoff_b_reg   <= 1'b0;
			sync_warn_reg <= 1'b0;
		end else if (i_ce) begin
			state_reg     <= state_next;
			svoff_a_reg   <= svoff_a_next;
			svoff_b_reg   <= svoff_b_next;
			sync_warn_reg <= sync_warn_next;
		end
	end

	// ---------------------------------------------------------------
	// Inter-axis deviation
	// ---------------------------------------------------------------
	logic signed [32:0] dev_next, dev_reg;
	logic [32:0]        mag;
	logic [36:0]        warn_thr;
	logic               servo_on_any;
	logic               dev_alarm_a_reg, dev_alarm_a_next;
	logic               dev_alarm_b_reg, dev_alarm_b_next;
	logic               dev_warn_reg, dev_warn_next;
	logic               alarm_trip, warn_trip;

	// The divide by 100 is a wide combinational path; it is kept since the
	// level may change at any time and must apply immediately.
	always_comb begin
		dev_next = 33'(signed'(i_axis_a.feedback_position)) -
			33'(signed'(i_axis_b.feedback_position));
		mag      = dev_next[32] ? 33'(-dev_next) : 33'(dev_next);
		warn_thr = (37'(level_reg) * 37'(pct_reg)) /
			gssdm_pkg::PCT_DIVISOR;
		servo_on_any = i_axis_a.servo_on || i_axis_b.servo_on;
		alarm_trip = servo_on_any && (level_reg != 30'h0) &&
			(37'(mag) > 37'(level_reg));
		warn_trip  = servo_on_any && (level_reg != 30'h0) &&
			(37'(mag) > warn_thr);
		// Alarm hits both axes together and holds until alarm reset.
		dev_alarm_a_next = alarm_trip ||
			(dev_alarm_a_reg && !i_alarm_reset);
		dev_alarm_b_next = alarm_trip ||
			(dev_alarm_b_reg && !i_alarm_reset);
		dev_warn_next    = warn_trip;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dev_reg         <= 33'sh0;
			dev_alarm_a_reg <= 1'b0;
			dev_alarm_b_reg <= 1'b0;
			dev_warn_reg    <= 1'b0;
		end else if (i_ce) begin
			dev_reg         <= dev_next;
			dev_alarm_a_reg <= dev_alarm_a_next;
			dev_alarm_b_reg <= dev_alarm_b_next;
			dev_warn_reg    <= dev_warn_next;
		end
	end

	// ---------------------------------------------------------------
	// Status words and event code
	// ---------------------------------------------------------------
	logic [31:0] word_a_reg, word_b_reg, word_a_next, word_b_next;
	logic [15:0] code_reg, code_next;
	logic        sync_active, sync_warn_shown;

	// Packs one axis into the host status word; reserved bits are zero.
	function automatic logic [31:0] pack_word(
		input gssdm_pkg::gssdm_axis_io_type io, input logic stop_flag);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[gssdm_pkg::STS_SLOWDOWN_BIT +: 7] = {io.emergency_stop_input,
			io.latch_input_3, io.latch_input_2, io.latch_input_1,
			io.reverse_overtravel, io.forward_overtravel,
			io.homing_slowdown_switch};
		w[gssdm_pkg::STS_BRAKE_BIT +: 7] = {io.origin_reached,
			io.positioning_complete, io.approach_window_flag,
			io.distribution_complete, io.reverse_soft_limit,
			io.forward_soft_limit, io.holding_brake_output};
		w[gssdm_pkg::STS_TORQUE_LIM_BIT +: 4] = {io.zero_speed_flag,
			io.speed_match_flag, io.speed_limit_flag, io.torque_limit_flag};
		w[gssdm_pkg::STS_GEN_IN1_BIT +: 7] = io.general_input;
		w[gssdm_pkg::STS_SYNC_STOP_BIT] = stop_flag;
		return w;
	endfunction

	// Alarm outranks warnings in the single code shown to the host.
	always_comb begin
		sync_active     = (state_reg != gssdm_pkg::GSSDM_NORMAL);
		sync_warn_shown = sync_warn_reg &&
			!mask_reg[gssdm_pkg::MASK_SYNC_HIDE];
		word_a_next = pack_word(i_axis_a.io, sync_active);
		word_b_next = pack_word(i_axis_b.io, sync_active);
		if (dev_alarm_a_reg || dev_alarm_b_reg)
			code_next = gssdm_pkg::CODE_DEV_ALARM;
		else if (dev_warn_reg)
			code_next = gssdm_pkg::CODE_DEV_WARN;
		else if (sync_warn_shown)
			code_next = gssdm_pkg::CODE_SYNC_WARN;
		else
			code_next = gssdm_pkg::CODE_NONE;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			word_a_reg <= 32'h0000_0000;
			word_b_reg <= 32'h0000_0000;
			code_reg   <= gssdm_pkg::CODE_NONE;
		end else if (i_ce) begin
			word_a_reg <= word_a_next;
			word_b_reg <= word_b_next;
			code_reg   <= code_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_io_signal_status_word_a = word_a_reg;
	assign o_io_signal_status_word_b = word_b_reg;
	assign o_sync_stop_status        = word_a_reg[gssdm_pkg::STS_SYNC_STOP_BIT];
	assign o_svoff_a                 = svoff_a_reg;
	assign o_svoff_b                 = svoff_b_reg;
	assign o_stop_method             = method_reg;  // Shared by both axes.
	assign o_sync_warning            = sync_warn_reg &&
		!mask_reg[gssdm_pkg::MASK_SYNC_HIDE];
	assign o_dev_alarm_a             = dev_alarm_a_reg;
	assign o_dev_alarm_b             = dev_alarm_b_reg;
	assign o_dev_warning             = dev_warn_reg;
	assign o_event_code              = code_reg;
	assign o_deviation               = dev_reg;

endmodule

// *** bench/gssdm_chk.sv ***
// Checker for gssdm_core: deviation trips, status word and stop tracking.
// Sees only the block's ports and is bound into every gssdm_core.
`timescale 1ns/10ps

module gssdm_chk (
	// Clock, reset and block inputs
	input wire logic                      i_clk,
	input wire logic                      i_rst,
	input wire logic                      i_ce,
	input wire logic                      i_param_wr,
	input wire logic [2:0]                i_param_sel,
	input wire logic [31:0]               i_param_data,
	input wire logic [1:0]                i_sync_mode,
	input wire gssdm_pkg::gssdm_axis_type i_axis_a,
	input wire gssdm_pkg::gssdm_axis_type i_axis_b,
	input wire logic                      i_host_svoff,
	input wire logic                      i_warn_clear,
	input wire logic                      i_alarm_reset,
	// Block outputs
	input wire logic [31:0]               o_io_signal_status_word_a,
	input wire logic [31:0]               o_io_signal_status_word_b,
	input wire logic                      o_sync_stop_status,
	input wire logic                      o_svoff_a,
	input wire logic                      o_svoff_b,
	input wire logic [3:0]                o_stop_method,
	input wire logic                      o_sync_warning,
	input wire logic                      o_dev_alarm_a,
	input wire logic                      o_dev_alarm_b,
	input wire logic                      o_dev_warning,
	input wire logic [15:0]               o_event_code,
	input wire logic [32:0]               o_deviation
);
	// ----------------------------------------------------------------
	// Parameter shadow and trip conditions
	// ----------------------------------------------------------------
	logic [29:0] lvl_reg;
	logic [6:0]  pct_reg;
	logic        hide_reg;
	logic [32:0] diff;
	logic [32:0] mag;
	logic [36:0] thr;
	logic        servo;
	logic        acond;
	logic        wcond;

	// Shadow copies clamp exactly as the block does, so limits line up.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lvl_reg  <= gssdm_pkg::ALARM_LEVEL_RST;
			pct_reg  <= gssdm_pkg::WARN_PCT_RST;
			hide_reg <= 1'b0;
		end else if (i_ce && i_param_wr) begin
			if (i_param_sel == gssdm_pkg::PSEL_ALARM_LEVEL)
				lvl_reg <= (|i_param_data[31:30]) ?
					gssdm_pkg::ALARM_LEVEL_MAX : i_param_data[29:0];
			if (i_param_sel == gssdm_pkg::PSEL_WARN_PERCENT)
				pct_reg <= (i_param_data < 32'h0000_000a) ?
					gssdm_pkg::WARN_PCT_MIN :
					(i_param_data > 32'h0000_0064) ?
					gssdm_pkg::WARN_PCT_MAX : i_param_data[6:0];
			if (i_param_sel == gssdm_pkg::PSEL_WARN_MASK)
				hide_reg <= i_param_data[gssdm_pkg::MASK_SYNC_HIDE];
		end
	end

	// Magnitude compare lets a deviation of either sign trip.
	always_comb begin
		diff  = {i_axis_a.feedback_position[31], i_axis_a.feedback_position}
			- {i_axis_b.feedback_position[31], i_axis_b.feedback_position};
		mag   = diff[32] ? (~diff + 33'h0_0000_0001) : diff;
		thr   = ({7'h00, lvl_reg} * {30'h0, pct_reg}) / gssdm_pkg::PCT_DIVISOR;
		servo = i_axis_a.servo_on | i_axis_b.servo_on;
		acond = servo && (lvl_reg != 30'h0) && (mag > {3'h0, lvl_reg});
		wcond = servo && (lvl_reg != 30'h0) && ({4'h0, mag} > thr);
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_reserved_zero: assert property (o_io_signal_status_word_a[0] == 1'b0 &&
		o_io_signal_status_word_a[8] == 1'b0 &&
		o_io_signal_status_word_b[23:20] == 4'h0)
		else $error("reserved status bits not zero");
	a_status_bit_mirror: assert property (o_io_signal_status_word_a[31] ==
		o_sync_stop_status && o_io_signal_status_word_b[31] == o_sync_stop_status)
		else $error("status bit 31 differs from stop status");
	a_mode3_no_status: assert property ((i_sync_mode ==
		gssdm_pkg::SYNC_MODE_SVOFF) [*3] |-> !o_sync_stop_status)
		else $error("stop status set in servo-off mode");
	a_mode3_both_off: assert property (i_ce && i_sync_mode ==
		gssdm_pkg::SYNC_MODE_SVOFF && (i_axis_a.alarm != i_axis_b.alarm)
		|=> o_svoff_a && o_svoff_b)
		else $error("servo-off mode did not turn both axes off");
	a_dev_value: assert property (i_ce |=> o_deviation == $past(diff))
		else $error("deviation is not A minus B");
	a_dev_alarm_trip: assert property (i_ce && acond |=>
		o_dev_alarm_a && o_dev_alarm_b)
		else $error("deviation alarm missing");
	a_dev_warn_live: assert property (i_ce |=>
		o_dev_warning == $past(wcond))
		else $error("deviation warning wrong");
	a_alarm_both_axes: assert property (o_dev_alarm_a == o_dev_alarm_b)
		else $error("deviation alarm on one axis only");
	a_alarm_code_out: assert property (i_ce && acond ##1 i_ce |=>
		o_event_code == gssdm_pkg::CODE_DEV_ALARM)
		else $error("alarm code not shown");
	a_sync_warn_mask: assert property (o_sync_warning |-> !hide_reg)
		else $error("masked stop warning visible");
	a_sync_warn_raise: assert property (i_ce && !i_param_wr &&
		i_sync_mode != gssdm_pkg::SYNC_MODE_OFF && !hide_reg && !i_warn_clear &&
		(i_axis_a.alarm != i_axis_b.alarm) |=> o_sync_warning)
		else $error("stop warning missing");

	c_stop: cover property (o_sync_stop_status);
	c_warn_only: cover property (o_dev_warning && !o_dev_alarm_a);
	c_both_off: cover property (o_svoff_a && o_svoff_b);
endmodule

bind gssdm_core gssdm_chk u_chk (.*);

// *** bench/gssdm_axis_model.sv ***
// Behavioural model of one drive axis as seen by gssdm_core.
// Assumes the bench changes its commands at the falling clock edge.
`timescale 1ns/10ps

module gssdm_axis_model (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// Bench commands and the block's servo-off request
	input  wire logic                 i_req,
	input  wire logic                 i_svoff,
	input  wire logic                 i_alarm,
	input  wire logic [31:0]          i_pos,
	input  wire logic [15:0]          i_speed,
	input  wire logic [24:0]          i_io,
	// Axis state handed to the block
	output gssdm_pkg::gssdm_axis_type o_axis
);
	logic on_reg;
	logic on_next;
	logic req_reg;

	// A servo-off pulse sticks until the bench lowers and raises the request.
	always_comb begin
		on_next = i_req & (on_reg | ~req_reg) & ~i_svoff;
	end

	// Registered servo state, cleared by reset.
	always_ff @(posedge i_clk) begin
		on_reg  <= i_rst ? 1'b0 : on_next;
		req_reg <= i_rst ? 1'b0 : i_req;
	end

	// Position data stays valid so alarms lead to a real follow stop.
	assign o_axis = {on_reg, i_alarm, 1'b1, i_pos, i_speed, i_io};
endmodule

// *** bench/tb.sv ***
// Self-checking bench for gssdm_core with two behavioural axis models.
// Assumes the package and design compile first; one 100 MHz clock.
`timescale 1ns/10ps

module tb;
	// ----------------------------------------------------------------
	// Signals, axis commands and counters
	// ----------------------------------------------------------------
	logic i_clk, i_rst, i_ce, i_param_wr, i_host_svoff;
	logic i_warn_clear, i_alarm_reset;
	logic [2:0] i_param_sel;
	logic [31:0] i_param_data, o_io_signal_status_word_a;
	logic [31:0] o_io_signal_status_word_b;
	logic [1:0] i_sync_mode;
	gssdm_pkg::gssdm_axis_type i_axis_a, i_axis_b;
	logic o_sync_stop_status, o_svoff_a, o_svoff_b, o_sync_warning;
	logic o_dev_alarm_a, o_dev_alarm_b, o_dev_warning;
	logic [3:0] o_stop_method;
	logic [15:0] o_event_code;
	logic [32:0] o_deviation;
	logic req[2], alm[2];
	logic [31:0] pos[2];
	logic [15:0] spd[2];
	logic [24:0] io[2];
	int mismatches = 0;
	int total_checks = 0;
	int cyc = 0;

	gssdm_core dut (.*);
	gssdm_axis_model u_axis_a (.i_clk(i_clk), .i_rst(i_rst), .i_req(req[0]),
		.i_svoff(o_svoff_a), .i_alarm(alm[0]), .i_pos(pos[0]),
		.i_speed(spd[0]), .i_io(io[0]), .o_axis(i_axis_a));
	gssdm_axis_model u_axis_b (.i_clk(i_clk), .i_rst(i_rst), .i_req(req[1]),
		.i_svoff(o_svoff_b), .i_alarm(alm[1]), .i_pos(pos[1]),
		.i_speed(spd[1]), .i_io(io[1]), .o_axis(i_axis_b));

	// Free-running clock.
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Hang guard: the sequence needs well under a thousand cycles.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// The spare cycle keeps the strobe from being set twice in one step.
	task automatic wr(input logic [2:0] sel, input logic [31:0] data);
		i_param_wr = 1'b1;
		i_param_sel = sel;
		i_param_data = data;
		tick(1);
		i_param_wr = 1'b0;
		tick(1);
	endtask

	task automatic svon();
		req = '{1'b0, 1'b0};
		tick(1);
		req = '{1'b1, 1'b1};
		tick(2);
	endtask

	task automatic clr();
		i_warn_clear = 1'b1;
		i_alarm_reset = 1'b1;
		tick(1);
		i_warn_clear = 1'b0;
		i_alarm_reset = 1'b0;
		tick(1);
	endtask

	function automatic logic [31:0] wexp(input logic [24:0] v);
		return {1'b0, v[24:18], 4'h0, v[17:14], v[13:7], 1'b0, v[6:0], 1'b0};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence: reset, status word, deviation, then stop tracking.
	initial begin
		{i_rst, i_ce, i_param_wr, i_host_svoff} = 4'b1100;
		{i_warn_clear, i_alarm_reset, i_param_sel, i_sync_mode} = 7'h00;
		i_param_data = 32'h0;
		req = '{1'b1, 1'b1};
		alm = '{1'b0, 1'b0};
		pos = '{32'h0, 32'h0};
		spd = '{16'h1000, 16'h1000};
		io = '{25'h0, 25'h0};
		tick(10);
		i_rst = 1'b0;
		tick(2);
		chk(o_stop_method, gssdm_pkg::STOP_DYN_BRAKE);
		for (int k = 0; k < 2; k++) begin
			io[0] = k ? 25'h0aa_aaaa : 25'h155_5555;
			io[1] = ~io[0];
			tick(2);
			chk(o_io_signal_status_word_a, wexp(io[0]));
			chk(o_io_signal_status_word_b, wexp(io[1]));
		end
		$display("test status word done");
		pos[0] = 32'h0050_0001;
		tick(1);
		chk({o_dev_alarm_a, o_dev_alarm_b, o_dev_warning}, 3'h7);
		chk(o_deviation, 33'h0_0050_0001);
		tick(1);
		chk(o_event_code, gssdm_pkg::CODE_DEV_ALARM);
		pos[0] = 32'h0050_0000;
		tick(1);
		chk({o_dev_alarm_a, o_dev_warning}, 2'h2);
		clr();
		chk(o_dev_alarm_a, 1'b0);
		pos = '{32'h0, 32'h0050_0001};
		tick(1);
		chk({o_dev_alarm_b, o_dev_warning}, 2'h3);
		chk(o_deviation, 33'h1_ffaf_ffff);
		pos[1] = 32'h0;
		clr();
		// Both axes sit at the origin before the limits are lowered.
		wr(gssdm_pkg::PSEL_ALARM_LEVEL, 32'h0000_03e8);
		wr(gssdm_pkg::PSEL_WARN_PERCENT, 32'h0000_0005);
		pos[0] = 32'h0000_0065;
		tick(2);
		chk({o_dev_alarm_a, o_dev_warning}, 2'h1);
		chk(o_event_code, gssdm_pkg::CODE_DEV_WARN);
		pos[0] = 32'h0000_0064;
		tick(1);
		chk(o_dev_warning, 1'b0);
		wr(gssdm_pkg::PSEL_ALARM_LEVEL, 32'h0);
		pos[0] = 32'h7fff_0000;
		tick(2);
		chk({o_dev_alarm_a, o_dev_warning}, 2'h0);
		req = '{1'b0, 1'b0};
		tick(2);
		wr(gssdm_pkg::PSEL_ALARM_LEVEL, 32'h0050_0000);
		wr(gssdm_pkg::PSEL_WARN_PERCENT, 32'h0000_0064);
		chk({o_dev_alarm_a, o_dev_warning}, 2'h0);
		pos[0] = 32'h0;
		svon();
		$display("test deviation done");
		i_sync_mode = 2'h1;
		alm[1] = 1'b1;
		tick(1);
		chk(o_sync_warning, 1'b1);
		tick(1);
		chk(o_sync_stop_status, 1'b1);
		chk(o_io_signal_status_word_b[31], 1'b1);
		chk(o_event_code, gssdm_pkg::CODE_SYNC_WARN);
		spd[1] = 16'h00ff;
		alm[1] = 1'b0;
		tick(3);
		chk({o_sync_stop_status, i_axis_a.servo_on}, 2'h0);
		spd[1] = 16'h1000;
		svon();
		for (int d = 0; d < 16; d++) begin
			wr(gssdm_pkg::PSEL_WARN_MASK, 32'(d) << 4);
			chk(o_sync_warning, d < 8);
		end
		wr(gssdm_pkg::PSEL_WARN_MASK, 32'h0);
		clr();
		chk(o_sync_warning, 1'b0);
		$display("test follow stop done");
		alm[1] = 1'b1;
		tick(3);
		chk(o_sync_stop_status, 1'b1);
		alm[0] = 1'b1;
		tick(3);
		alm = '{1'b0, 1'b0};
		chk(o_sync_stop_status, 1'b0);
		tick(2);
		chk(i_axis_a.servo_on, 1'b1);
		wr(gssdm_pkg::PSEL_STOP_METHOD, 32'h0000_0001);
		chk(o_stop_method, 4'h1);
		wr(gssdm_pkg::PSEL_STOP_METHOD, 32'h0);
		clr();
		$display("test cancel done");
		i_sync_mode = 2'h3;
		alm[0] = 1'b1;
		tick(1);
		alm[0] = 1'b0;
		tick(2);
		chk({i_axis_a.servo_on, i_axis_b.servo_on}, 2'h0);
		chk(o_sync_stop_status, 1'b0);
		i_sync_mode = 2'h0;
		clr();
		svon();
		$display("test servo-off mode done");
		i_ce = 1'b0;
		pos[0] = 32'h0000_0010;
		tick(2);
		chk(o_deviation, 33'h0);
		i_ce = 1'b1;
		tick(1);
		chk(o_deviation, 33'h0_0000_0010);
		pos[0] = 32'h0;
		i_sync_mode = 2'h1;
		alm[1] = 1'b1;
		tick(2);
		i_host_svoff = 1'b1;
		tick(1);
		i_host_svoff = 1'b0;
		alm[1] = 1'b0;
		tick(2);
		chk({o_sync_stop_status, i_axis_a.servo_on}, 2'h0);
		$display("test hold and host stop done");
		wrap_up();
	end
endmodule
